//--- hw/spfs_pkg.sv
// package: shared pin function select constants and types
package spfs_pkg;

  // ***************************************************************
  // reset values of the pin function selections
  // ***************************************************************
  localparam logic RST_TIMER_SEL = 1'b0;   // address bit eighteen after reset
  localparam logic RST_DREQ_SEL  = 1'b0;   // async clock zero after reset
  localparam logic RST_TEND_SEL  = 1'b0;   // async clock one after reset
  localparam logic RST_CTS_SEL   = 1'b0;   // clocked serial rx after reset

  // ***************************************************************
  // inactive levels toward the peripherals
  // ***************************************************************
  localparam logic IDLE_LOW_ACT  = 1'b1;   // active-low inputs idle high
  localparam logic IDLE_HIGH_ACT = 1'b0;   // active-high inputs idle low
  localparam logic TEND_IDLE     = 1'b1;   // transfer end is active low

  // ***************************************************************
  // input synchroniser depth
  // ***************************************************************
  localparam int SYNC_STAGES = 3;

  // one-hot state of the address/timer pin
  typedef enum logic [1:0] {
    SPFS_PIN_ADDR  = 2'h1,
    SPFS_PIN_TIMER = 2'h2
  } spfs_addr_pin_t;

endpackage

//--- hw/spfs_sel_if.sv
// interface: function selections passed from the decoder to the pin logic
`timescale 1ns/100ps
interface spfs_sel_if;
  logic timer_sel;
  logic dreq_sel;
  logic tend_sel;
  logic cts_sel;
  modport src (output timer_sel, output dreq_sel, output tend_sel, output cts_sel);
  modport dst (input timer_sel, input dreq_sel, input tend_sel, input cts_sel);
endinterface

//--- hw/spfs_sync.sv
// module: three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module spfs_sync
  import spfs_pkg::*;
#(
  parameter logic RST_VAL = 1'b1
) (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic nrst_in,
  input  wire logic en_in,
  // data
  input  wire logic d_in,
  output logic      q_out
);

  logic [SYNC_STAGES-1:0] stage;

  // stage 0 feeds only stage 1; output moves when stages 1 and 2 agree
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      stage <= {SYNC_STAGES{RST_VAL}};
    end else if (en_in) begin
      stage <= {stage[SYNC_STAGES-2:0], d_in};
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      q_out <= RST_VAL;
    end else if (en_in && (stage[1] == stage[2])) begin
      q_out <= stage[2];
    end
  end

endmodule

//--- hw/spfs_top.sv
// module: shared pin function selection for four multiplexed package pins
//
// What this block does
// R1: under reset the address/timer pin is set to address bit eighteen but not driven
// R2: either timer output control bit set routes timer pulse; both clear restores address
// R3: under reset the clock-zero pin is async clock zero
// R4: either dma mode high bit set makes clock-zero pin dma request zero input
// R5: under reset the clock-one pin is async clock one
// R6: clock-one disable set selects transfer end zero, clear selects async clock one
// R7: under reset the receive pin is clocked serial receive data
// R8: clear-to-send enable set makes receive pin clear-to-send one input
// R9: transfer end, when routed, is driven low in the final dma write cycle
// R10: timer function presents active-high pulse of reload timer channel 1
// R11: async clock pins carry generator clocks out, or feed external clocks in
// R12: external requesters drive dma request zero low when ready
// R13: function follows control bits, changing from the cycle after a write
// R14: inputs of an unrouted function are held inactive toward their peripheral
`timescale 1ns/100ps
module spfs_top
  import spfs_pkg::*;
(
  // clock, reset, enable
  input  wire logic clk_in,
  input  wire logic nrst_in,
  input  wire logic clk_en_in,
  // control bits from peripheral registers
  input  wire logic timer_out_ctrl_hi_in,
  input  wire logic timer_out_ctrl_lo_in,
  input  wire logic dma_dest_mode_hi_in,
  input  wire logic dma_src_mode_hi_in,
  input  wire logic clock_one_disable_in,
  input  wire logic clear_to_send_one_en_in,
  // peripheral-side outputs to the pins
  input  wire logic address_bit_eighteen_in,
  input  wire logic timer_pulse_out_in,
  input  wire logic transfer_end_zero_in,
  input  wire logic async_clock_zero_o_in,
  input  wire logic async_clock_zero_oe_in,
  input  wire logic async_clock_one_o_in,
  input  wire logic async_clock_one_oe_in,
  // pin inputs
  input  wire logic pin_addr_in,
  input  wire logic pin_clk0_in,
  input  wire logic pin_clk1_in,
  input  wire logic pin_rx_in,
  // pin outputs and enables
  output logic      pin_addr_out,
  output logic      pin_addr_oe_out,
  output logic      pin_clk0_out,
  output logic      pin_clk0_oe_out,
  output logic      pin_clk1_out,
  output logic      pin_clk1_oe_out,
  // inputs toward the peripherals
  output logic      async_clock_zero_out,
  output logic      async_clock_one_out,
  output logic      dma_request_zero_n_out,
  output logic      clocked_serial_rx_out,
  output logic      clear_to_send_one_n_out,
  // current selections
  output logic      timer_sel_out,
  output logic      dreq_sel_out,
  output logic      tend_sel_out,
  output logic      cts_sel_out
);

  // ***************************************************************
  // selection registers
  // ***************************************************************
  spfs_sel_if     sel ();
  spfs_addr_pin_t addr_state;
  logic           s_clk0;
  logic           s_clk1;
  logic           s_rx;
  logic           next_timer_sel;
  logic           next_dreq_sel;
  logic           next_tend_sel;
  logic           next_cts_sel;

  // decode straight from the control bits
  always_comb begin
    next_timer_sel = timer_out_ctrl_hi_in | timer_out_ctrl_lo_in; // R2
    next_dreq_sel  = dma_dest_mode_hi_in | dma_src_mode_hi_in;    // R4
    next_tend_sel  = clock_one_disable_in;                        // R6
    next_cts_sel   = clear_to_send_one_en_in;                     // R8
  end

  // registered so all outputs come from flops; takes effect next cycle
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sel.timer_sel <= RST_TIMER_SEL; // R1
      sel.dreq_sel  <= RST_DREQ_SEL;  // R3
      sel.tend_sel  <= RST_TEND_SEL;  // R5
      sel.cts_sel   <= RST_CTS_SEL;   // R7
    end else if (clk_en_in) begin
      sel.timer_sel <= next_timer_sel; // R13
      sel.dreq_sel  <= next_dreq_sel;  // R13
      sel.tend_sel  <= next_tend_sel;  // R13
      sel.cts_sel   <= next_cts_sel;   // R13
    end
  end

  // address/timer pin state tracks the timer selection
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      addr_state <= SPFS_PIN_ADDR; // R1
    end else if (clk_en_in) begin
      unique case (addr_state)
        SPFS_PIN_ADDR:  if (next_timer_sel) addr_state <= SPFS_PIN_TIMER;  // R2
        SPFS_PIN_TIMER: if (!next_timer_sel) addr_state <= SPFS_PIN_ADDR;  // R2
      endcase
    end
  end

  // ***************************************************************
  // pin input synchronisers
  // ***************************************************************
  spfs_sync #(.RST_VAL(IDLE_HIGH_ACT)) u_sync_clk0 (
    .clk_in  (clk_in),
    .nrst_in (nrst_in),
    .en_in   (clk_en_in),
    .d_in    (pin_clk0_in),
    .q_out   (s_clk0)
  );

  spfs_sync #(.RST_VAL(IDLE_HIGH_ACT)) u_sync_clk1 (
    .clk_in  (clk_in),
    .nrst_in (nrst_in),
    .en_in   (clk_en_in),
    .d_in    (pin_clk1_in),
    .q_out   (s_clk1)
  );

  spfs_sync #(.RST_VAL(IDLE_HIGH_ACT)) u_sync_rx (
    .clk_in  (clk_in),
    .nrst_in (nrst_in),
    .en_in   (clk_en_in),
    .d_in    (pin_rx_in),
    .q_out   (s_rx)
  );

  // ***************************************************************
  // pin drivers
  // ***************************************************************
  // address pin is output-only; the address pin input is not used here
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin_addr_out    <= 1'b0;
      pin_addr_oe_out <= 1'b0; // address bus floats during reset
    end else if (clk_en_in) begin
      pin_addr_oe_out <= 1'b1;
      if (next_timer_sel) begin
        pin_addr_out <= timer_pulse_out_in;      // R10
      end else begin
        pin_addr_out <= address_bit_eighteen_in; // R2
      end
    end
  end

  // clock-zero pin: never driven while it is a dma request input
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin_clk0_out    <= 1'b0;
      pin_clk0_oe_out <= 1'b0;
    end else if (clk_en_in) begin
      pin_clk0_out    <= async_clock_zero_o_in;                    // R11
      pin_clk0_oe_out <= async_clock_zero_oe_in & ~next_dreq_sel;  // R4
    end
  end

  // clock-one pin: transfer end is an active-low push output
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin_clk1_out    <= TEND_IDLE;
      pin_clk1_oe_out <= 1'b0;
    end else if (clk_en_in) begin
      if (next_tend_sel) begin
        pin_clk1_out    <= transfer_end_zero_in; // R9
        pin_clk1_oe_out <= 1'b1;                 // R6
      end else begin
        pin_clk1_out    <= async_clock_one_o_in;  // R11
        pin_clk1_oe_out <= async_clock_one_oe_in; // R6
      end
    end
  end

  // ***************************************************************
  // inputs toward peripherals, unrouted ones held inactive
  // ***************************************************************
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      async_clock_zero_out    <= IDLE_HIGH_ACT;
      async_clock_one_out     <= IDLE_HIGH_ACT;
      dma_request_zero_n_out  <= IDLE_LOW_ACT;
      clocked_serial_rx_out   <= IDLE_HIGH_ACT;
      clear_to_send_one_n_out <= IDLE_LOW_ACT;
    end else if (clk_en_in) begin
      // requester pulls low when ready; sensing mode belongs to the dma
      dma_request_zero_n_out  <= sel.dreq_sel ? s_clk0 : IDLE_LOW_ACT;   // R12 R14
      async_clock_zero_out    <= sel.dreq_sel ? IDLE_HIGH_ACT : s_clk0;  // R11 R14
      async_clock_one_out     <= sel.tend_sel ? IDLE_HIGH_ACT : s_clk1;  // R11 R14
      clear_to_send_one_n_out <= sel.cts_sel ? s_rx : IDLE_LOW_ACT;      // R8 R14
      clocked_serial_rx_out   <= sel.cts_sel ? IDLE_HIGH_ACT : s_rx;     // R8 R14
    end
  end

  // selection status
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      timer_sel_out <= RST_TIMER_SEL;
      dreq_sel_out  <= RST_DREQ_SEL;
      tend_sel_out  <= RST_TEND_SEL;
      cts_sel_out   <= RST_CTS_SEL;
    end else if (clk_en_in) begin
      timer_sel_out <= next_timer_sel;
      dreq_sel_out  <= next_dreq_sel;
      tend_sel_out  <= next_tend_sel;
      cts_sel_out   <= next_cts_sel;
    end
  end

  // ***************************************************************
  // assertions
  // ***************************************************************
  timer_route_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // R10
    clk_en_in && (timer_out_ctrl_hi_in || timer_out_ctrl_lo_in)
      |=> pin_addr_out == $past(timer_pulse_out_in))
    else $error("timer pulse not routed");
  addr_route_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // R2
    clk_en_in && !timer_out_ctrl_hi_in && !timer_out_ctrl_lo_in
      |=> pin_addr_out == $past(address_bit_eighteen_in))
    else $error("address bit not restored");
  dreq_nodrive_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // R4
    clk_en_in && (dma_dest_mode_hi_in || dma_src_mode_hi_in) |=> !pin_clk0_oe_out)
    else $error("clock zero pin driven in dma mode");
  tend_drive_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // R9
    clk_en_in && clock_one_disable_in
      |=> pin_clk1_oe_out && pin_clk1_out == $past(transfer_end_zero_in))
    else $error("transfer end not driven");
  clk1_route_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // R6
    clk_en_in && !clock_one_disable_in
      |=> pin_clk1_oe_out == $past(async_clock_one_oe_in))
    else $error("clock one enable wrong");
  // gating reads the registered selection, which equals cts_sel_out at each edge
  cts_idle_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // R14
    clk_en_in && !cts_sel_out |=> clear_to_send_one_n_out)
    else $error("unrouted clear to send active");
  dreq_idle_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // R14
    clk_en_in && !dreq_sel_out |=> dma_request_zero_n_out)
    else $error("unrouted dma request active");
  sel_follow_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // R13
    clk_en_in |=> cts_sel_out == $past(clear_to_send_one_en_in)
                  && tend_sel_out == $past(clock_one_disable_in))
    else $error("selection did not follow");
  rx_route_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // R8
    clk_en_in && cts_sel_out |=> clocked_serial_rx_out == IDLE_HIGH_ACT)
    else $error("rx not idled");

  timer_cov_c: cover property (@(posedge clk_in) disable iff (!nrst_in)
    addr_state == SPFS_PIN_ADDR ##1 addr_state == SPFS_PIN_TIMER);
  dreq_cov_c:  cover property (@(posedge clk_in) disable iff (!nrst_in)
    dreq_sel_out && !dma_request_zero_n_out);
  tend_cov_c:  cover property (@(posedge clk_in) disable iff (!nrst_in)
    tend_sel_out && !pin_clk1_out);
  cts_cov_c:   cover property (@(posedge clk_in) disable iff (!nrst_in)
    cts_sel_out && !clear_to_send_one_n_out);

endmodule

//--- testbench/spfs_pin_model.sv
// partner model: external devices on the shared clock pins
`timescale 1ns/100ps
module spfs_pin_model (
  // clock
  input  wire logic clk_in,
  // device side of the pins
  input  wire logic pin0_in,
  input  wire logic pin0_oe_in,
  input  wire logic pin1_in,
  input  wire logic pin1_oe_in,
  // external drivers
  input  wire logic ext0_en_in,
  input  wire logic ext0_in,
  input  wire logic ext1_en_in,
  input  wire logic ext1_in,
  // resolved wire levels
  output logic      wire0_out,
  output logic      wire1_out
);
  // ***************************************************************
  // wire resolution
  // ***************************************************************
  logic flt;
  // a released wire toggles so a stale level never passes for a driven one
  initial flt = 1'b0;
  always @(posedge clk_in) flt <= ~flt;
  // the requester pulls the request line low when ready, as the bench commands
  assign wire0_out = pin0_oe_in ? pin0_in : (ext0_en_in ? ext0_in : flt);
  assign wire1_out = pin1_oe_in ? pin1_in : (ext1_en_in ? ext1_in : flt);
endmodule

//--- testbench/spfs_top_tb.sv
// testbench: shared pin function select driven through its control and pin ports
`timescale 1ns/100ps
module spfs_top_tb
  import spfs_pkg::*;
;
  logic clk_in, nrst_in, clk_en_in, d;
  logic toc_hi, toc_lo, dm_hi, sm_hi, ck1_dis, cts_en;
  logic addr18, tpulse, transfer_end_zero, ck0_o, ck0_oe, ck1_o, ck1_oe, rx;
  logic ext0_en, ext0, ext1_en, ext1, w_ck0, w_ck1;
  logic apin_o, apin_oe, ck0_po, ck0_poe, ck1_po, ck1_poe;
  logic ack0, ack1, dreq_n, srx, cts_n, tsel, dsel, esel, csel;
  int   num_errors, n_tests;

  // 100 MHz clock
  initial clk_in = 1'b0;
  always #5 clk_in = ~clk_in;

  spfs_top i_dut (.clk_in(clk_in), .nrst_in(nrst_in), .clk_en_in(clk_en_in),
    .timer_out_ctrl_hi_in(toc_hi), .timer_out_ctrl_lo_in(toc_lo),
    .dma_dest_mode_hi_in(dm_hi), .dma_src_mode_hi_in(sm_hi),
    .clock_one_disable_in(ck1_dis), .clear_to_send_one_en_in(cts_en),
    .address_bit_eighteen_in(addr18), .timer_pulse_out_in(tpulse),
    .transfer_end_zero_in(transfer_end_zero), .async_clock_zero_o_in(ck0_o),
    .async_clock_zero_oe_in(ck0_oe), .async_clock_one_o_in(ck1_o),
    .async_clock_one_oe_in(ck1_oe), .pin_addr_in(1'b0), .pin_clk0_in(w_ck0),
    .pin_clk1_in(w_ck1), .pin_rx_in(rx), .pin_addr_out(apin_o), .pin_addr_oe_out(apin_oe),
    .pin_clk0_out(ck0_po), .pin_clk0_oe_out(ck0_poe), .pin_clk1_out(ck1_po),
    .pin_clk1_oe_out(ck1_poe), .async_clock_zero_out(ack0), .async_clock_one_out(ack1),
    .dma_request_zero_n_out(dreq_n), .clocked_serial_rx_out(srx),
    .clear_to_send_one_n_out(cts_n), .timer_sel_out(tsel), .dreq_sel_out(dsel),
    .tend_sel_out(esel), .cts_sel_out(csel));

  spfs_pin_model i_model (.clk_in(clk_in), .pin0_in(ck0_po), .pin0_oe_in(ck0_poe),
    .pin1_in(ck1_po), .pin1_oe_in(ck1_poe), .ext0_en_in(ext0_en), .ext0_in(ext0),
    .ext1_en_in(ext1_en), .ext1_in(ext1), .wire0_out(w_ck0), .wire1_out(w_ck1));

  // ***************************************************************
  // helpers
  // ***************************************************************
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic check(input string name, input logic seen, input logic exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %b seen %b", name, exp, seen);
    end
  endtask

  task automatic end_sim;
    if (num_errors == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    {toc_hi, toc_lo, dm_hi, sm_hi, ck1_dis, cts_en} = '0;
    {addr18, tpulse, transfer_end_zero, ck0_o, ck0_oe, ck1_o, ck1_oe, rx} = '0;
    {ext0_en, ext0, ext1_en, ext1} = '0;
    nrst_in = 1'b0;
    clk_en_in = 1'b1;
    num_errors = 0;
    n_tests = 0;
    wait_cyc(11);
    // defaults held under reset
    check("timer_sel", tsel, RST_TIMER_SEL);
    check("addr_oe", apin_oe, 1'b0);
    check("dreq_sel", dsel, RST_DREQ_SEL);
    check("tend_sel", esel, RST_TEND_SEL);
    check("cts_sel", csel, RST_CTS_SEL);
    check("dreq_n", dreq_n, IDLE_LOW_ACT);
    @(posedge clk_in);
    nrst_in <= 1'b1;
    ext0_en <= 1'b1;
    ck0_o <= 1'b1;
    // every timer control code, address and pulse told apart
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_in);
      {toc_hi, toc_lo, tpulse} <= i[2:0];
      addr18 <= ~i[0];
      wait_cyc(1);
      check("timer_sel", tsel, i[2] | i[1]);
      check("addr_pin", apin_o, (i[2] | i[1]) ? i[0] : ~i[0]);
      check("addr_oe", apin_oe, 1'b1);
    end
    // every dma mode code, clock zero in input and output mode
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_in);
      {dm_hi, sm_hi, ck0_oe} <= i[2:0];
      ext0 <= ~i[2];
      wait_cyc(1);
      d = i[2] | i[1];
      check("dreq_sel", dsel, d);
      check("clk0_oe", ck0_poe, ~d & i[0]);
      wait_cyc(7);
      if (i != 1) begin
        check("dreq_n", dreq_n, d ? ~i[2] : IDLE_LOW_ACT);
        check("clk0_in", ack0, d ? IDLE_HIGH_ACT : ~i[2]);
      end else begin
        check("clk0_pin", ck0_po, 1'b1);
      end
    end
    // clock one disable with transfer end both levels
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_in);
      {ck1_dis, transfer_end_zero} <= i[1:0];
      ck1_oe <= 1'b1;
      ck1_o <= ~i[0];
      wait_cyc(1);
      check("tend_sel", esel, i[1]);
      check("clk1_oe", ck1_poe, 1'b1);
      check("clk1_pin", ck1_po, i[1] ? i[0] : ~i[0]);
      wait_cyc(7);
      // driven clock loops back through the pin into the generator input
      if (i[1]) begin
        check("clk1_in", ack1, IDLE_HIGH_ACT);
      end else begin
        check("clk1_in", ack1, ~i[0]);
      end
    end
    // clock one back to an external input clock
    @(posedge clk_in);
    {ck1_dis, ck1_oe, ext1_en, ext1} <= 4'h3;
    wait_cyc(1);
    check("clk1_oe", ck1_poe, 1'b0);
    wait_cyc(7);
    check("clk1_in", ack1, 1'b1);
    // receive pin as serial data or clear to send
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_in);
      {cts_en, rx} <= i[1:0];
      wait_cyc(1);
      check("cts_sel", csel, i[1]);
      wait_cyc(7);
      check("rx_in", srx, i[1] ? IDLE_HIGH_ACT : i[0]);
      check("cts_n", cts_n, i[1] ? i[0] : IDLE_LOW_ACT);
    end
    // a frozen clock enable must hold the selection
    @(posedge clk_in);
    {clk_en_in, toc_hi, toc_lo} <= 3'h0;
    wait_cyc(3);
    check("timer_sel", tsel, 1'b1);
    @(posedge clk_in);
    clk_en_in <= 1'b1;
    wait_cyc(1);
    check("timer_sel", tsel, 1'b0);
    // second reset in mid run, with clear to send still selected
    @(posedge clk_in);
    nrst_in <= 1'b0;
    wait_cyc(1);
    check("cts_sel", csel, RST_CTS_SEL);
    check("addr_oe", apin_oe, 1'b0);
    // release again: the still-set control bits take over at the first edge
    @(posedge clk_in);
    nrst_in <= 1'b1;
    wait_cyc(2);
    check("cts_sel", csel, 1'b1);
    check("addr_oe", apin_oe, 1'b1);
    check("addr_pin", apin_o, 1'b0);
    end_sim();
  end
endmodule
